// *** bench/motor_bank.sv ***
`timescale 1ns/10ps
// ------------------------------------------
// Failure contacts of the four pump motors
// ------------------------------------------
module motor_bank (
  input  wire logic       core_clk_in,
  input  wire logic [3:0] fault_in,
  output logic      [3:0] interlock_out
);
  // A failed motor closes its contact one clock later and opens it one clock after the fault clears
  always_ff @(posedge core_clk_in) begin
    interlock_out <= fault_in;
  end
endmodule // motor_bank

// *** bench/pump_staging_autochange_sva.sv ***
`timescale 1ns/10ps
// ------------------------------------------
// Port checker
// ------------------------------------------
module pump_staging_sva #(
  parameter int MOTORS = 4
) (
  input wire logic              core_clk_in,
  input wire logic              rst_in,
  input wire logic              psel_in,
  input wire logic              penable_in,
  input wire logic              pwrite_in,
  input wire logic [7:0]        paddr_in,
  input wire logic [31:0]       pwdata_in,
  input wire logic              pready_out,
  input wire logic              pslverr_out,
  input wire logic              drive_run_in,
  input wire logic              const_speed_in,
  input wire logic [MOTORS-1:0] interlock_in,
  input wire logic [15:0]       freq_cmd_in,
  input wire logic [MOTORS-1:0] motor_on_out,
  input wire logic [1:0]        drive_motor_out,
  input wire logic              drive_block_out,
  input wire logic [15:0]       freq_out
);
  logic [10:0] cfg;
  wire         acc = psel_in && penable_in;
  wire         bad = paddr_in[1:0] != 2'b00 || paddr_in > 8'h48;
  // Shadow of the configuration word
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) cfg <= 11'h085;
    else if (acc && pwrite_in && paddr_in == 8'h00) cfg <= pwdata_in[10:0];
  end
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  sequence stop_s; $fell(drive_run_in); endsequence
  sequence plain_s; (!cfg[9] && !(cfg[10] && const_speed_in)) [*2]; endsequence
  ready_high_a: assert property (pready_out) else $error("ready low");
  bad_addr_a: assert property (acc && bad |-> pslverr_out) else $error("no error");
  good_addr_a: assert property (acc && !bad |-> !pslverr_out) else $error("false error");
  stop_clear_a: assert property (stop_s |=> motor_on_out == '0)
    else $error("motors kept after stop");
  one_step_a: assert property (drive_run_in && $past(drive_run_in)
    |-> $countones(motor_on_out & ~$past(motor_on_out)) <= 1)
    else $error("two motors started at once");
  fail_off_a: assert property (cfg[8] && $past(cfg[8])
    |-> (motor_on_out & $past(interlock_in)
         & (($past(cfg[1:0]) == 2'd2) ? 4'hf : 4'h7)) == '0)
    else $error("failed motor running");
  no_main_a: assert property ((cfg[1:0] != 2'd2) [*3] |-> drive_motor_out == 2'd0)
    else $error("drive index outside main mode");
  block_cause_a: assert property (drive_block_out |-> $past(drive_run_in)
    && $past(cfg[1:0]) == 2'd2 && $past(cfg[8]))
    else $error("block without cause");
  freq_pass_a: assert property (plain_s |=> freq_out == $past(freq_cmd_in))
    else $error("frequency shifted");
endmodule // pump_staging_sva

bind pump_staging_autochange pump_staging_sva #(.MOTORS(MOTORS)) u_sva (
  .core_clk_in, .rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
  .pready_out, .pslverr_out, .drive_run_in, .const_speed_in, .interlock_in,
  .freq_cmd_in, .motor_on_out, .drive_motor_out, .drive_block_out, .freq_out);

// *** bench/testbench.sv ***
`timescale 1ns/10ps
module testbench;
  logic        core_clk_in = 0, rst_in = 1, psel = 0, penable = 0, pwrite = 0;
  logic        run = 0, cs = 0, err, rdy, serr, blk;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, rd, prd;
  logic [15:0] fb = 0, cmd = 0, spd = 0, perr = 0, dcl = 0, rnd, fout;
  logic [3:0]  fault = 0, ilock, mon;
  logic [1:0]  dmot;
  int          failures = 0, checks = 0, n;
  always #2.5 core_clk_in = ~core_clk_in;
  pump_staging_autochange #(.MS_CYCLES(10)) u_pump_staging_autochange (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prd),
    .pready_out(rdy), .pslverr_out(serr), .drive_run_in(run), .const_speed_in(cs),
    .interlock_in(ilock), .main_speed_in(spd), .pid_error_in(perr),
    .feedback_in(fb), .freq_cmd_in(cmd), .dc_link_in(dcl), .motor_on_out(mon),
    .drive_motor_out(dmot), .drive_block_out(blk), .freq_out(fout));
  motor_bank u_motor_bank (.core_clk_in(core_clk_in), .fault_in(fault), .interlock_out(ilock));
  // Verdict and end of run
  task end_sim;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  // One APB transfer, held until ready is seen high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk_in);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk_in);
      n++;
    end while (rdy !== 1'b1 && n < 20);
    if (rdy !== 1'b1) begin
      failures++;
      end_sim();
    end
    rd = prd;
    err = serr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Bounded wait for a motor pattern
  task wait_mon(input logic [3:0] exp);
    for (n = 0; n < 4000 && mon !== exp; n++) @(posedge core_clk_in);
    chk(mon, exp);
    if (n == 4000) end_sim();
  endtask
  function logic [15:0] byp(input logic [15:0] f);
    return 16'(32'(f) * pump_staging_pkg::MAX_FREQ_RST / pump_staging_pkg::FB_MAX_RST);
  endfunction
  initial begin
    void'($urandom(32'hc3a6c67f));
    repeat (8) @(posedge core_clk_in);
    rst_in <= 1'b0;
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h85);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h1140);
    apb(1'b0, 8'h4c, 32'h0);
    chk(err, 1'b1);
    apb(1'b1, 8'h02, 32'h0);
    chk(err, 1'b1);
    rnd = 16'($urandom_range(100, 1));
    apb(1'b1, 8'h0c, rnd);
    apb(1'b0, 8'h0c, 32'h0);
    chk(rd, rnd);
    apb(1'b1, 8'h08, 32'h0);
    apb(1'b1, 8'h00, 32'h485);
    cmd <= 16'($urandom_range(6000));
    run <= 1'b1;
    dcl <= 16'd600;
    repeat (3) @(posedge core_clk_in);
    chk(fout, cmd);
    cs <= 1'b1;
    repeat (3) @(posedge core_clk_in);
    chk(fout, cmd + pump_staging_pkg::REGEN_COMP_RST);
    dcl <= 16'd300;
    repeat (3) @(posedge core_clk_in);
    chk(fout, cmd);
    spd <= 16'd6000;
    perr <= 16'd200;
    wait_mon(4'b0001);
    spd <= 16'd0;
    perr <= 16'd0;
    wait_mon(4'b0000);
    apb(1'b1, 8'h00, 32'h365);
    fb <= 16'($urandom_range(332));
    repeat (3) @(posedge core_clk_in);
    chk(fout, byp(fb));
    fb <= 16'd334;
    wait_mon(4'b0001);
    fb <= 16'd667;
    wait_mon(4'b0011);
    fault <= 4'b0001;
    wait_mon(4'b0110);
    fault <= 4'b0000;
    run <= 1'b0;
    wait_mon(4'b0000);
    apb(1'b1, 8'h00, 32'h166);
    run <= 1'b1;
    fault <= 4'b0001;
    for (n = 0; n < 100 && blk !== 1'b1; n++) @(posedge core_clk_in);
    chk(blk, 1'b1);
    for (n = 0; n < 100 && dmot !== 2'd1; n++) @(posedge core_clk_in);
    chk(dmot, 2'd1);
    end_sim();
  end
endmodule // testbench

// *** design/pump_staging_autochange.sv ***
`timescale 1ns/10ps
// Functional notes
// - Aux rotation mode starts aux motors in order from the selected starting motor.
// - Aux mode flags auto change when accumulated run time exceeds change time.
// - Stop under auto change advances the starting aux motor, wrapping to motor one.
// - Main mode flags auto change from drive-connected motor run time.
// - Main mode puts selected motor on drive, others as aux in ascending wrap.
// - Main mode stop under auto change moves the next motor onto the drive.
// - Enabled interlock inputs decide whether each motor may run.
// - None or aux mode maps interlocks 1-3 to relay 1, relay 2, output 1.
// - Main mode maps interlocks 1-4 to relay 1, relay 2, outputs 1 and 2.
// - Failed idle aux motor leaves the order and returns when released.
// - Failed running aux motor stops and the next one in order starts.
// - Failed drive motor blocks output, next motor takes drive, old goes last.
// - Bypass sets main speed from feedback and stages aux motors by feedback.
// - Bypass starts aux n at n times max feedback over aux count.
// - Regeneration avoidance acts only at constant speed.
// - DC link rise limited to settable level, 350 V or 700 V default.
// - Avoidance shifts output frequency by at most the compensation limit.
// - DC link voltage regulated by a PI loop with settable gains.
// - Aux starts when speed above start frequency, delay passed, error above threshold.
// - Aux stops when speed below stop frequency, delay passed, error below threshold.
// - No-rotation mode keeps the start order fixed.
module pump_staging_autochange #(
  parameter int          MS_CYCLES  = pump_staging_pkg::MS_TICK_CYCLES,
  parameter logic        HIGH_CLASS = 1'b0,
  parameter int          MOTORS     = 4
) (
  input  wire logic              core_clk_in,
  input  wire logic              rst_in,
  input  wire logic              psel_in,
  input  wire logic              penable_in,
  input  wire logic              pwrite_in,
  input  wire logic [7:0]        paddr_in,
  input  wire logic [31:0]       pwdata_in,
  output logic [31:0]            prdata_out,
  output logic                   pready_out,
  output logic                   pslverr_out,
  input  wire logic              drive_run_in,
  input  wire logic              const_speed_in,
  input  wire logic [MOTORS-1:0] interlock_in,
  input  wire logic [15:0]       main_speed_in,
  input  wire logic [15:0]       pid_error_in,
  input  wire logic [15:0]       feedback_in,
  input  wire logic [15:0]       freq_cmd_in,
  input  wire logic [15:0]       dc_link_in,
  output logic [MOTORS-1:0]      motor_on_out,
  output logic [1:0]             drive_motor_out,
  output logic                   drive_block_out,
  output logic [15:0]            freq_out
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Scan the order from base over cnt positions; first or last hit in mask
  function automatic logic [2:0] scan(input logic [1:0] base, input logic [2:0] cnt,
                                      input logic [3:0] mask, input logic last);
    logic [2:0] r;
    logic [1:0] m;
    r = 3'b000;
    m = base;
    for (int i = 0; i < 4; i++) begin
      if (3'(i) < cnt && mask[m] && (last || !r[2])) r = {1'b1, m};
      m = (3'({1'b0, m}) + 3'd1 >= cnt) ? 2'd0 : m + 2'd1;
    end
    return r;
  endfunction

  // Count of set bits in a motor mask
  function automatic logic [2:0] ones(input logic [3:0] v);
    return 3'(v[0]) + 3'(v[1]) + 3'(v[2]) + 3'(v[3]);
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Settings written over the bus
  logic [31:0] config_reg;
  logic [15:0] change_time, start_dly, stop_dly, pdiff, fb_max, max_freq;
  logic [15:0] regen_level, regen_comp, regen_p, regen_i;
  logic [15:0] start_freq [4];
  logic [15:0] stop_freq [4];
  // Staging and rotation state
  logic [1:0]  start_pos, main_idx;
  logic [3:0]  running;
  logic [2:0]  want;
  logic [15:0] runtime_min;
  logic        change_flag, run_q;
  // Time base and staging delay timers
  logic [17:0] ms_cnt;
  logic [6:0]  deci_cnt;
  logic [9:0]  min_cnt;
  logic [15:0] up_tmr, dn_tmr;
  logic signed [31:0] i_acc;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // Configuration fields; pool counts every motor in the rotation, the drive motor included in main mode
  wire pump_staging_pkg::change_mode_e mode = pump_staging_pkg::change_mode_e'(
         config_reg[pump_staging_pkg::MODE_LSB +: 2]);
  wire        main_mode = (mode == pump_staging_pkg::CHANGE_MAIN);
  wire [2:0]  sel_cfg   = pwdata_in[pump_staging_pkg::START_SEL_LSB +: 3]; // CONFIG write
  wire [2:0]  aux_cnt   = config_reg[pump_staging_pkg::AUX_CNT_LSB +: 3];
  wire        ilock_en  = config_reg[pump_staging_pkg::ILOCK_EN_BIT];
  wire        bypass    = config_reg[pump_staging_pkg::BYPASS_BIT];
  wire        regen_en  = config_reg[pump_staging_pkg::REGEN_EN_BIT];
  wire [2:0]  pool      = main_mode ? ((aux_cnt >= 3'd4) ? 3'd4 : aux_cnt + 3'd1)
                                    : ((aux_cnt >= 3'd4) ? 3'd4 : aux_cnt);
  wire [3:0]  pool_mask = 4'((5'h01 << pool) - 5'h01);
  wire [1:0]  sel_pos   = (sel_cfg == 3'd0) ? 2'd0 : 2'(sel_cfg - 3'd1);

  // APB access phases
  wire        setup   = psel_in & ~penable_in;
  wire        wr      = psel_in & penable_in & pwrite_in;
  wire [1:0]  slot    = paddr_in[3:2];
  wire        in_sf   = (paddr_in[7:4] == pump_staging_pkg::START_FREQ_OFS[7:4]);
  wire        in_pf   = (paddr_in[7:4] == pump_staging_pkg::STOP_FREQ_OFS[7:4]);
  // A STATUS or RUNTIME write falls to default and is ignored
  wire        mapped  = (paddr_in[1:0] == 2'b00) && (paddr_in <= pump_staging_pkg::RUNTIME_OFS);

  // Interlock map; only three in non-main modes
  wire [3:0]  failed   = ilock_en ? (interlock_in & (main_mode ? 4'hf : 4'h7)) : 4'h0;
  wire [3:0]  main_bit = main_mode ? 4'(4'h1 << main_idx) : 4'h0;
  wire [1:0]  main_nx  = (3'({1'b0, main_idx}) + 3'd1 >= pool) ? 2'd0 : main_idx + 2'd1;
  wire [1:0]  base     = main_mode ? main_nx : start_pos;
  wire [3:0]  idle_ok  = ~running & ~failed & ~main_bit & pool_mask;
  wire [2:0]  up_pick  = scan(base, pool, idle_ok, 1'b0);
  wire [2:0]  dn_pick  = scan(base, pool, running, 1'b1);
  wire [2:0]  run_n    = ones(running);
  wire [3:0]  main_ok  = ~failed & pool_mask & ~main_bit;
  wire [2:0]  main_new = scan(main_nx, pool, main_ok, 1'b0);
  wire        main_bad = main_mode & drive_run_in & |(failed & main_bit);

  // Slow ticks
  wire ms_tick   = (ms_cnt == 18'(MS_CYCLES - 1));
  wire deci_tick = ms_tick && (deci_cnt == pump_staging_pkg::MS_PER_DECI - 7'd1);
  wire min_tick  = deci_tick && (min_cnt == pump_staging_pkg::DECI_PER_MIN - 10'd1);

  // Staging conditions
  wire signed [16:0] err_s  = 17'($signed(pid_error_in));
  wire signed [16:0] pd_s   = $signed({1'b0, pdiff});
  wire up_cond = up_pick[2] && (main_speed_in > start_freq[up_pick[1:0]])
                 && (err_s > pd_s);
  wire dn_cond = dn_pick[2] && (main_speed_in < stop_freq[dn_pick[1:0]])
                 && (err_s < pd_s);
  wire up_go   = up_cond && deci_tick && (up_tmr >= start_dly);
  wire dn_go   = dn_cond && deci_tick && (dn_tmr >= stop_dly);

  // Bypass: count levels n * max / aux_cnt reached by feedback
  wire [18:0] fb_scaled = 19'(feedback_in) * 19'(aux_cnt);
  wire [2:0]  byp_want  = (aux_cnt == 3'd0) ? 3'd0
                        : ((fb_scaled >= 19'(fb_max) * 19'(aux_cnt)) ? aux_cnt
                        : 3'(fb_scaled / 19'((fb_max == 16'h0) ? 16'h1 : fb_max)));
  wire [31:0] byp_num   = 32'(feedback_in) * 32'(max_freq);
  wire [15:0] byp_freq  = 16'(byp_num / 32'((fb_max == 16'h0) ? 16'h1 : fb_max));

  // Rotation on stop
  wire stop_evt = run_q & ~drive_run_in;
  wire rotate   = stop_evt & change_flag & (mode != pump_staging_pkg::CHANGE_NONE);
  wire [1:0] next_start = (3'({1'b0, start_pos}) + 3'd1 >= pool) ? 2'd0
                                                              : start_pos + 2'd1;

  // Regeneration avoidance PI
  wire        avoid   = regen_en & const_speed_in & drive_run_in & ~bypass;
  wire signed [16:0] dc_err = $signed({1'b0, dc_link_in}) - $signed({1'b0, regen_level});
  wire signed [31:0] p_term = 32'(dc_err) * $signed({16'h0, regen_p}) / 32'sd1000;
  wire signed [31:0] i_term = i_acc / $signed({16'h0, regen_i});
  wire signed [31:0] pi_sum = p_term + i_term;
  wire [15:0] comp = (!avoid || pi_sum <= 0) ? 16'h0
                   : (pi_sum >= $signed({16'h0, regen_comp})) ? regen_comp
                   : 16'(pi_sum);
  wire [16:0] f_sum  = 17'(freq_cmd_in) + 17'(comp);

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      config_reg  <= pump_staging_pkg::CONFIG_RST;
      change_time <= pump_staging_pkg::CHANGE_TIME_RST;
      start_dly   <= pump_staging_pkg::START_DLY_RST;
      stop_dly    <= pump_staging_pkg::STOP_DLY_RST;
      pdiff       <= pump_staging_pkg::PDIFF_RST;
      fb_max      <= pump_staging_pkg::FB_MAX_RST;
      max_freq    <= pump_staging_pkg::MAX_FREQ_RST;
      regen_level <= HIGH_CLASS ? pump_staging_pkg::REGEN_LVL_HIGH
                                : pump_staging_pkg::REGEN_LVL_LOW;
      regen_comp  <= pump_staging_pkg::REGEN_COMP_RST;
      regen_p     <= pump_staging_pkg::REGEN_P_RST;
      regen_i     <= pump_staging_pkg::REGEN_I_RST;
      // All four frequency slots share one reset value
      for (int i = 0; i < 4; i++) begin
        start_freq[i] <= pump_staging_pkg::START_FREQ_RST;
        stop_freq[i]  <= pump_staging_pkg::STOP_FREQ_RST;
      end
    end else if (wr) begin
      unique case (paddr_in)
        pump_staging_pkg::CONFIG_OFS:      config_reg  <= {21'h0, pwdata_in[10:0]};
        pump_staging_pkg::CHANGE_TIME_OFS: change_time <= pwdata_in[15:0];
        pump_staging_pkg::DELAYS_OFS: begin
          start_dly <= pwdata_in[15:0];
          stop_dly  <= pwdata_in[31:16];
        end
        pump_staging_pkg::PDIFF_OFS:       pdiff       <= pwdata_in[15:0];
        pump_staging_pkg::FB_MAX_OFS:      fb_max      <= pwdata_in[15:0];
        pump_staging_pkg::MAX_FREQ_OFS:    max_freq    <= pwdata_in[15:0];
        pump_staging_pkg::REGEN_LEVEL_OFS: regen_level <= pwdata_in[15:0];
        // Gains and limits beyond their range are clamped on write
        pump_staging_pkg::REGEN_COMP_OFS:
          regen_comp <= (pwdata_in[15:0] > pump_staging_pkg::REGEN_COMP_MAX)
                        ? pump_staging_pkg::REGEN_COMP_MAX : pwdata_in[15:0];
        pump_staging_pkg::REGEN_GAIN_OFS: begin
          regen_p <= (pwdata_in[15:0] > pump_staging_pkg::REGEN_P_MAX)
                     ? pump_staging_pkg::REGEN_P_MAX : pwdata_in[15:0];
          regen_i <= (pwdata_in[31:16] < pump_staging_pkg::REGEN_I_MIN)
                     ? pump_staging_pkg::REGEN_I_MIN
                     : (pwdata_in[31:16] > pump_staging_pkg::REGEN_I_MAX)
                     ? pump_staging_pkg::REGEN_I_MAX : pwdata_in[31:16];
        end
        default: begin
          if (in_sf) start_freq[slot] <= pwdata_in[15:0];
          if (in_pf) stop_freq[slot]  <= pwdata_in[15:0];
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read data, latched in the setup cycle
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      prdata_out  <= 32'h0;
      pslverr_out <= 1'b0;
    end else if (setup) begin
      // Unmapped or unaligned addresses answer with an error; data is zero except for unaligned reads in the frequency tables
      pslverr_out <= ~mapped;
      unique case (paddr_in)
        pump_staging_pkg::CONFIG_OFS:      prdata_out <= config_reg;
        pump_staging_pkg::CHANGE_TIME_OFS: prdata_out <= {16'h0, change_time};
        pump_staging_pkg::DELAYS_OFS:      prdata_out <= {stop_dly, start_dly};
        pump_staging_pkg::PDIFF_OFS:       prdata_out <= {16'h0, pdiff};
        pump_staging_pkg::FB_MAX_OFS:      prdata_out <= {16'h0, fb_max};
        pump_staging_pkg::MAX_FREQ_OFS:    prdata_out <= {16'h0, max_freq};
        pump_staging_pkg::REGEN_LEVEL_OFS: prdata_out <= {16'h0, regen_level};
        pump_staging_pkg::REGEN_COMP_OFS:  prdata_out <= {16'h0, regen_comp};
        pump_staging_pkg::REGEN_GAIN_OFS:  prdata_out <= {regen_i, regen_p};
        pump_staging_pkg::STATUS_OFS:
          prdata_out <= {11'h0, change_flag, 2'b00, start_pos, 2'b00, main_idx,
                         1'b0, want, 1'b0, run_n, running};
        pump_staging_pkg::RUNTIME_OFS:     prdata_out <= {16'h0, runtime_min};
        default: prdata_out <= in_sf ? {16'h0, start_freq[slot]}
                             : in_pf ? {16'h0, stop_freq[slot]} : 32'h0;
      endcase
    end
  end

  // Zero wait states: every access ends in its first access cycle
  assign pready_out = 1'b1;

  // ----------------------------------------------------------------
  // Time base: ms, 0.1 s and minute ticks
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ms_cnt   <= 18'h0;
      deci_cnt <= 7'h0;
      min_cnt  <= 10'h0;
    end else begin
      // Tenths and minutes advance only on ms ticks
      ms_cnt <= ms_tick ? 18'h0 : ms_cnt + 18'h1;
      if (ms_tick) deci_cnt <= deci_tick ? 7'h0 : deci_cnt + 7'h1;
      if (deci_tick) min_cnt <= min_tick ? 10'h0 : min_cnt + 10'h1;
    end
  end

  // ----------------------------------------------------------------
  // Run time, auto change flag and rotation
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      runtime_min <= 16'h0;
      change_flag <= 1'b0;
      start_pos   <= 2'd0;
      main_idx    <= 2'd0;
      run_q       <= 1'b0;
      drive_block_out <= 1'b0;
    end else begin
      run_q           <= drive_run_in;
      drive_block_out <= main_bad;
      // A CONFIG write reloads the order; a stop under the flag rotates it
      if (wr && paddr_in == pump_staging_pkg::CONFIG_OFS) begin
        start_pos   <= sel_pos;
        main_idx    <= sel_pos;
        runtime_min <= 16'h0;
        change_flag <= 1'b0;
      end else if (rotate) begin
        start_pos   <= next_start;
        main_idx    <= main_nx;
        runtime_min <= 16'h0;
        change_flag <= 1'b0;
      end else begin
        // Failed drive motor hands the output to the next healthy one
        if (main_bad && main_new[2]) main_idx <= main_new[1:0];
        // Run time counts minutes while the drive runs, saturating
        if (min_tick && drive_run_in && runtime_min != 16'hffff)
          runtime_min <= runtime_min + 16'h1;
        if (mode != pump_staging_pkg::CHANGE_NONE && runtime_min > change_time)
          change_flag <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Aux staging: demand count, delay timers, relay set
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      want    <= 3'd0;
      up_tmr  <= 16'h0;
      dn_tmr  <= 16'h0;
      running <= 4'h0;
    // Drive stop clears demand, timers and every relay
    end else if (!drive_run_in) begin
      want    <= 3'd0;
      up_tmr  <= 16'h0;
      dn_tmr  <= 16'h0;
      running <= 4'h0;
    end else begin
      if (bypass) begin
        want <= byp_want;
      end else if (up_go) begin
        want <= want + 3'd1;
      end else if (dn_go && want != 3'd0) begin
        want <= want - 3'd1;
      end
      // Delay timers restart whenever their condition drops
      if (!up_cond || up_go) up_tmr <= 16'h0;
      else if (deci_tick && up_tmr != 16'hffff) up_tmr <= up_tmr + 16'h1;
      if (!dn_cond || dn_go) dn_tmr <= 16'h0;
      else if (deci_tick && dn_tmr != 16'hffff) dn_tmr <= dn_tmr + 16'h1;
      // One step per clock: drop all failed and drive relays first, then start one, then stop one
      if (|(running & (failed | main_bit)))
        running <= running & ~failed & ~main_bit;
      else if (run_n < want && up_pick[2])
        running <= running | 4'(4'h1 << up_pick[1:0]);
      else if (run_n > want && dn_pick[2])
        running <= running & ~4'(4'h1 << dn_pick[1:0]);
    end
  end

  // ----------------------------------------------------------------
  // Regeneration integrator and frequency output
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      i_acc    <= 32'sh0;
      freq_out <= 16'h0;
    end else begin
      // Integrator holds at the limit so it cannot wind up
      if (!avoid) i_acc <= 32'sh0;
      else if (ms_tick && !(comp == regen_comp && dc_err > 0))
        i_acc <= i_acc + 32'(dc_err);
      freq_out <= bypass ? byp_freq
                : (f_sum > 17'h0ffff) ? 16'hffff : f_sum[15:0];
    end
  end

  // Relay outputs and the motor on the drive output
  assign motor_on_out    = running;
  assign drive_motor_out = main_mode ? main_idx : 2'd0;
endmodule // pump_staging_autochange

// *** design/pump_staging_pkg.sv ***
package pump_staging_pkg;
  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CONFIG_OFS      = 8'h00;
  localparam logic [7:0] CHANGE_TIME_OFS = 8'h04;
  localparam logic [7:0] DELAYS_OFS      = 8'h08;
  localparam logic [7:0] PDIFF_OFS       = 8'h0c;
  localparam logic [7:0] START_FREQ_OFS  = 8'h10;
  localparam logic [7:0] STOP_FREQ_OFS   = 8'h20;
  localparam logic [7:0] FB_MAX_OFS      = 8'h30;
  localparam logic [7:0] MAX_FREQ_OFS    = 8'h34;
  localparam logic [7:0] REGEN_LEVEL_OFS = 8'h38;
  localparam logic [7:0] REGEN_COMP_OFS  = 8'h3c;
  localparam logic [7:0] REGEN_GAIN_OFS  = 8'h40;
  localparam logic [7:0] STATUS_OFS      = 8'h44;
  localparam logic [7:0] RUNTIME_OFS     = 8'h48;

  // ----------------------------------------------------------------
  // Configuration field positions
  // ----------------------------------------------------------------
  localparam int MODE_LSB      = 0;
  localparam int START_SEL_LSB = 2;
  localparam int AUX_CNT_LSB   = 5;
  localparam int ILOCK_EN_BIT  = 8;
  localparam int BYPASS_BIT    = 9;
  localparam int REGEN_EN_BIT  = 10;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] CONFIG_RST      = 32'h0000_0085; // aux mode, start 1, four aux
  localparam logic [15:0] CHANGE_TIME_RST = 16'h1140;      // 4416 min
  localparam logic [15:0] START_DLY_RST   = 16'h0258;      // 60.0 s in 0.1 s
  localparam logic [15:0] STOP_DLY_RST    = 16'h0258;
  localparam logic [15:0] PDIFF_RST       = 16'h0002;
  localparam logic [15:0] START_FREQ_RST  = 16'h1387;      // 49.99 Hz
  localparam logic [15:0] STOP_FREQ_RST   = 16'h05dc;      // 15.00 Hz
  localparam logic [15:0] FB_MAX_RST      = 16'h03e8;
  localparam logic [15:0] MAX_FREQ_RST    = 16'h1770;      // 60.00 Hz
  localparam logic [15:0] REGEN_LVL_LOW   = 16'h015e;      // 350 V
  localparam logic [15:0] REGEN_LVL_HIGH  = 16'h02bc;      // 700 V
  localparam logic [15:0] REGEN_COMP_RST  = 16'h0064;      // 1.00 Hz
  localparam logic [15:0] REGEN_COMP_MAX  = 16'h03e8;      // 10.00 Hz
  localparam logic [15:0] REGEN_P_RST     = 16'h01f4;      // 50.0 %
  localparam logic [15:0] REGEN_P_MAX     = 16'h03e8;      // 100.0 %
  localparam logic [15:0] REGEN_I_RST     = 16'h01f4;      // 500 ms
  localparam logic [15:0] REGEN_I_MIN     = 16'h0014;      // 20 ms
  localparam logic [15:0] REGEN_I_MAX     = 16'h7530;      // 30000 ms

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ        = 200;
  localparam int MS_TICK_US     = 1000;
  localparam int MS_TICK_CYCLES = MS_TICK_US * CLK_MHZ;
  localparam logic [6:0] MS_PER_DECI   = 7'd100;
  localparam logic [9:0] DECI_PER_MIN  = 10'd600;

  // ----------------------------------------------------------------
  // Auto change modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CHANGE_NONE = 2'b00,
    CHANGE_AUX  = 2'b01,
    CHANGE_MAIN = 2'b10
  } change_mode_e;
endpackage
